// *** uam_uart.sv ***
// Serial unit in asynchronous mode: Avalon-MM registers, transmitter, receiver, interrupt
`timescale 1ns/1ps
module uam_uart #(
  parameter int PRE_W = 10
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        serial_in_line_in,
  output logic             serial_out_line_out,
  output logic             tx_pin_serial_out,
  output logic             rx_pin_serial_out,
  output logic             irq_out
);

  typedef struct packed {
    logic [7:0]         mode;
    logic [2:0]         err;
    logic [3:0]         cksel;
    logic [7:0]         baud;
    logic [1:0]         sctl;
    logic [7:0]         txbuf;
    logic               txbuf_full;
    uam_pkg::uam_phase_t tx_ph;
    logic [7:0]         tx_data;
    logic [2:0]         tx_idx;
    logic               tx_stop2;
    logic [7:0]         tx_tmr;
    logic               tx_bit;
    logic               rx_sync1;
    logic               rx_sync2;
    uam_pkg::uam_phase_t rx_ph;
    logic [7:0]         rx_data;
    logic [2:0]         rx_idx;
    logic [7:0]         rx_tmr;
    logic               rx_perr;
    logic [7:0]         rxbuf;
    logic               rxbuf_full;
    logic [2:0]         irq_st;
    logic [2:0]         irq_mask;
    logic               ack;
    logic [31:0]        rdata;
    logic               line;
  } uam_state_t;

  uam_state_t st;
  uam_state_t next_st;

  logic       tick;
  logic       power;
  logic       tx_on;
  logic       rx_on;
  logic       char8;
  logic [1:0] par_sel;
  logic [2:0] last_idx;
  logic [7:0] baud_eff;
  logic       tx_bit_end;
  logic       rx_bit_end;
  logic       rx_half;
  logic       rx_in;
  logic       wr_go;
  logic       rd_go;
  logic [2:0] ev;
  logic [2:0] err_set;
  logic [7:0] wbyte;
  logic       wlane;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Reverse the character within its length, shared by both directions
  function automatic logic [7:0] uam_reorder(input logic [7:0] d, input logic len8);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7-i];
    end
    return len8 ? r : {1'b0, r[7:1]};
  endfunction : uam_reorder

  // Parity bit to send, or expected parity, over the used character bits
  function automatic logic uam_parity(input logic [7:0] d, input logic len8,
                                      input logic [1:0] sel);
    logic ones;
    ones = ^(len8 ? d : {1'b0, d[6:0]});
    unique case (sel)
      uam_pkg::PAR_EVEN: return ones;
      uam_pkg::PAR_ODD:  return ~ones;
      default:           return 1'b0;
    endcase
  endfunction : uam_parity

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler instance

  uam_prescaler #(
    .CNT_W (PRE_W)
  ) u_pre (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .run_in    (power),
    .sel_in    (st.cksel),
    .tick_out  (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoded configuration

  always_comb begin
    power    = st.mode[uam_pkg::MODE_POWER];
    tx_on    = power && st.mode[uam_pkg::MODE_TXEN];
    rx_on    = power && st.mode[uam_pkg::MODE_RXEN];
    char8    = st.mode[uam_pkg::MODE_CHAR];
    par_sel  = {st.mode[uam_pkg::MODE_PAR_HIGH], st.mode[uam_pkg::MODE_PAR_LOW]};
    last_idx = char8 ? 3'h7 : 3'h6;
    // Divisor below two would leave no half-bit point to sample at
    baud_eff = (st.baud < uam_pkg::BAUD_MIN) ? uam_pkg::BAUD_MIN : st.baud;
    tx_bit_end = tick && (st.tx_tmr == baud_eff - 8'h01);
    rx_bit_end = tick && (st.rx_tmr == baud_eff - 8'h01);
    rx_half    = tick && (st.rx_tmr == (baud_eff >> 1) - 8'h01);
    // Input reads high while the unit is off
    rx_in      = power ? st.rx_sync2 : 1'b1;
    wr_go      = avs_write_in && st.ack;
    rd_go      = avs_read_in && st.ack;
    wlane      = avs_byteenable_in[0];
    wbyte      = avs_writedata_in[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and bus handshake

  // One wait cycle per access: the second edge completes it
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !st.ack;
  assign avs_readdata_out    = st.rdata;
  assign serial_out_line_out = st.line;
  assign tx_pin_serial_out   = tx_on;
  assign rx_pin_serial_out   = rx_on;
  assign irq_out             = |(st.irq_st & st.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_st = st;
    ev      = '0;
    err_set = '0;

    // Bus: ack rises for exactly one cycle after a request is seen
    next_st.ack = (avs_read_in || avs_write_in) && !st.ack;
    if (avs_read_in && !st.ack) begin
      next_st.rdata = '0;
      unique case (avs_address_in)
        uam_pkg::ADDR_MODE:    next_st.rdata[7:0] = st.mode;
        uam_pkg::ADDR_ERRST:   next_st.rdata[2:0] = st.err;
        uam_pkg::ADDR_TXST:    next_st.rdata[1:0] = {st.txbuf_full,
                                                     st.tx_ph != uam_pkg::UAM_IDLE};
        uam_pkg::ADDR_CKSEL:   next_st.rdata[3:0] = st.cksel;
        uam_pkg::ADDR_BAUD:    next_st.rdata[7:0] = st.baud;
        uam_pkg::ADDR_SCTL:    next_st.rdata[1:0] = st.sctl;
        uam_pkg::ADDR_RXBUF:   next_st.rdata[7:0] = st.rxbuf;
        uam_pkg::ADDR_IRQST:   next_st.rdata[2:0] = st.irq_st;
        uam_pkg::ADDR_IRQMASK: next_st.rdata[2:0] = st.irq_mask;
        default:               next_st.rdata      = '0;
      endcase
    end

    // Register writes; only byte lane 0 carries data
    if (wr_go && wlane) begin
      unique case (avs_address_in)
        uam_pkg::ADDR_MODE:    next_st.mode     = wbyte;
        uam_pkg::ADDR_CKSEL:   next_st.cksel    = wbyte[3:0];
        uam_pkg::ADDR_BAUD:    next_st.baud     = wbyte;
        uam_pkg::ADDR_SCTL:    next_st.sctl     = wbyte[1:0];
        uam_pkg::ADDR_IRQMASK: next_st.irq_mask = wbyte[2:0];
        uam_pkg::ADDR_TXBUF: begin
          // Ignored unless powered and transmit-enabled
          if (tx_on) begin
            next_st.txbuf      = wbyte;
            next_st.txbuf_full = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Reading the receive buffer consumes it; reading the error register does too, except when powered with receive disabled
    if (rd_go && avs_address_in == uam_pkg::ADDR_ERRST) begin
      next_st.err = '0;
    end
    if (rd_go && avs_address_in == uam_pkg::ADDR_RXBUF) begin
      next_st.rxbuf_full = 1'b0;
    end

    // Receive input synchroniser
    next_st.rx_sync1 = serial_in_line_in;
    next_st.rx_sync2 = st.rx_sync1;

    // Transmitter
    next_st.tx_tmr = tx_bit_end ? 8'h00 : (tick ? st.tx_tmr + 8'h01 : st.tx_tmr);
    unique case (st.tx_ph)
      uam_pkg::UAM_IDLE: begin
        next_st.tx_bit = 1'b1;
        next_st.tx_tmr = 8'h00;
        if (st.txbuf_full) begin
          next_st.txbuf_full = 1'b0;
          next_st.tx_data = st.sctl[uam_pkg::SCTL_DIR] ?
                            uam_reorder(st.txbuf, char8) : st.txbuf;
          next_st.tx_idx  = 3'h0;
          next_st.tx_bit  = 1'b0;
          next_st.tx_ph   = uam_pkg::UAM_START;
        end
      end
      uam_pkg::UAM_START: begin
        if (tx_bit_end) begin
          next_st.tx_bit = st.tx_data[0];
          next_st.tx_ph  = uam_pkg::UAM_DATA;
        end
      end
      uam_pkg::UAM_DATA: begin
        if (tx_bit_end) begin
          if (st.tx_idx == last_idx) begin
            if (par_sel == uam_pkg::PAR_NONE) begin
              next_st.tx_bit   = 1'b1;
              next_st.tx_stop2 = st.mode[uam_pkg::MODE_STOP];
              next_st.tx_ph    = uam_pkg::UAM_STOP;
            end else begin
              // Parity over the character as sent, order does not matter
              next_st.tx_bit = uam_parity(st.tx_data, char8, par_sel);
              next_st.tx_ph  = uam_pkg::UAM_PARITY;
            end
          end else begin
            next_st.tx_idx = st.tx_idx + 3'h1;
            next_st.tx_bit = st.tx_data[st.tx_idx + 3'h1];
          end
        end
      end
      uam_pkg::UAM_PARITY: begin
        if (tx_bit_end) begin
          next_st.tx_bit   = 1'b1;
          next_st.tx_stop2 = st.mode[uam_pkg::MODE_STOP];
          next_st.tx_ph    = uam_pkg::UAM_STOP;
        end
      end
      uam_pkg::UAM_STOP: begin
        if (tx_bit_end) begin
          if (st.tx_stop2) begin
            next_st.tx_stop2 = 1'b0;
          end else begin
            ev[uam_pkg::IRQ_TXDONE] = 1'b1;
            next_st.tx_ph = uam_pkg::UAM_IDLE;
          end
        end
      end
      default: next_st.tx_ph = uam_pkg::UAM_IDLE;
    endcase

    // A write landing as the idle transmitter takes the old byte must refill the buffer
    if (wr_go && wlane && tx_on && avs_address_in == uam_pkg::ADDR_TXBUF) begin
      next_st.txbuf_full = 1'b1;
    end

    // Receiver, running alongside the transmitter
    next_st.rx_tmr = rx_bit_end ? 8'h00 : (tick ? st.rx_tmr + 8'h01 : st.rx_tmr);
    unique case (st.rx_ph)
      uam_pkg::UAM_IDLE: begin
        next_st.rx_tmr = 8'h00;
        if (!rx_in) begin
          next_st.rx_ph   = uam_pkg::UAM_START;
          next_st.rx_perr = 1'b0;
          next_st.rx_idx  = 3'h0;
          next_st.rx_data = 8'h00;
        end
      end
      uam_pkg::UAM_START: begin
        // Timer restarts at mid-start so later samples land mid-bit
        if (rx_half) begin
          next_st.rx_tmr = 8'h00;
          next_st.rx_ph  = rx_in ? uam_pkg::UAM_IDLE : uam_pkg::UAM_DATA;
        end
      end
      uam_pkg::UAM_DATA: begin
        if (rx_bit_end) begin
          next_st.rx_data[st.rx_idx] = rx_in;
          if (st.rx_idx == last_idx) begin
            next_st.rx_ph = (par_sel == uam_pkg::PAR_NONE) ?
                            uam_pkg::UAM_STOP : uam_pkg::UAM_PARITY;
          end else begin
            next_st.rx_idx = st.rx_idx + 3'h1;
          end
        end
      end
      uam_pkg::UAM_PARITY: begin
        if (rx_bit_end) begin
          // Zero parity is never checked
          next_st.rx_perr = (par_sel != uam_pkg::PAR_ZERO) &&
                            (rx_in != uam_parity(st.rx_data, char8, par_sel));
          next_st.rx_ph   = uam_pkg::UAM_STOP;
        end
      end
      uam_pkg::UAM_STOP: begin
        // Only the first stop bit is checked, so a second one is never waited for
        if (rx_bit_end) begin
          next_st.rx_ph   = uam_pkg::UAM_IDLE;
          next_st.rxbuf   = st.sctl[uam_pkg::SCTL_DIR] ?
                            uam_reorder(st.rx_data, char8) : st.rx_data;
          next_st.rxbuf_full = 1'b1;
          err_set[uam_pkg::ERR_PARITY]  = st.rx_perr;
          err_set[uam_pkg::ERR_FRAME]   = !rx_in;
          err_set[uam_pkg::ERR_OVERRUN] = st.rxbuf_full;
          if (|err_set && !st.mode[uam_pkg::MODE_ERRIRQ]) begin
            ev[uam_pkg::IRQ_RXERR] = 1'b1;
          end else begin
            ev[uam_pkg::IRQ_RXDONE] = 1'b1;
          end
        end
      end
      default: next_st.rx_ph = uam_pkg::UAM_IDLE;
    endcase
    next_st.err = next_st.err | err_set;                              // Set wins over read clear

    // Transmit-enable low resets the transmitter synchronously
    if (!tx_on) begin
      next_st.tx_ph      = uam_pkg::UAM_IDLE;
      next_st.tx_bit     = 1'b1;
      next_st.tx_tmr     = 8'h00;
      next_st.txbuf_full = 1'b0;
      ev[uam_pkg::IRQ_TXDONE] = 1'b0;
    end
    if (!rx_on) begin
      next_st.rx_ph  = uam_pkg::UAM_IDLE;
      next_st.rx_tmr = 8'h00;
      ev[uam_pkg::IRQ_RXDONE] = 1'b0;
      ev[uam_pkg::IRQ_RXERR]  = 1'b0;
      next_st.err = st.err;
      if (!power) begin
        // Power off clears the error status and the receive buffer with its full flag
        next_st.err        = '0;
        next_st.rxbuf      = 8'h00;
        next_st.rxbuf_full = 1'b0;
      end
    end

    // Line: idle high, inverted on request, forced high while off
    next_st.line = power ? (next_st.tx_bit ^ st.sctl[uam_pkg::SCTL_POL]) : 1'b1;

    // Sticky interrupt status, write one to clear, new event wins
    if (wr_go && wlane && avs_address_in == uam_pkg::ADDR_IRQST) begin
      next_st.irq_st = st.irq_st & ~wbyte[2:0];
    end
    next_st.irq_st = next_st.irq_st | ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // All three enables low leaves everything idle: the stop mode
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st          <= '0;
      st.mode     <= uam_pkg::MODE_RESET;
      st.cksel    <= uam_pkg::CKSEL_RESET;
      st.baud     <= uam_pkg::BAUD_RESET;
      st.tx_ph    <= uam_pkg::UAM_IDLE;
      st.rx_ph    <= uam_pkg::UAM_IDLE;
      st.tx_bit   <= 1'b1;
      st.rx_sync1 <= 1'b1;
      st.rx_sync2 <= 1'b1;
      st.line     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

endmodule : uam_uart

// *** uam_pkg.sv ***
// Package: register map, field positions, reset values and state types of the serial unit
package uam_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [5:0] ADDR_MODE    = 6'h00; // operation_mode_reg
  localparam logic [5:0] ADDR_ERRST   = 6'h04; // rx_error_status_reg
  localparam logic [5:0] ADDR_TXST    = 6'h08; // tx_status_reg
  localparam logic [5:0] ADDR_CKSEL   = 6'h0C; // clock_select_reg
  localparam logic [5:0] ADDR_BAUD    = 6'h10; // baud_divisor_reg
  localparam logic [5:0] ADDR_SCTL    = 6'h14; // serial_control_reg
  localparam logic [5:0] ADDR_TXBUF   = 6'h18; // tx_buffer, write only
  localparam logic [5:0] ADDR_RXBUF   = 6'h1C; // receive buffer, read only
  localparam logic [5:0] ADDR_IRQST   = 6'h20; // interrupt status, write one to clear
  localparam logic [5:0] ADDR_IRQMASK = 6'h24; // interrupt mask, 1 = enabled

  // operation_mode_reg fields
  localparam int MODE_POWER    = 7; // unit_power_bit
  localparam int MODE_TXEN     = 6; // tx_enable_bit
  localparam int MODE_RXEN     = 5; // rx_enable_bit
  localparam int MODE_PAR_HIGH = 4; // parity_sel_high
  localparam int MODE_PAR_LOW  = 3; // parity_sel_low
  localparam int MODE_CHAR     = 2; // char_length_sel: 1 = 8 bits, 0 = 7 bits
  localparam int MODE_STOP     = 1; // stop_length_sel: 1 = 2 stop bits
  localparam int MODE_ERRIRQ   = 0; // rx_error_irq_mode
  localparam logic [7:0] MODE_RESET = 8'h01;

  // Parity selection {parity_sel_high, parity_sel_low}
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // serial_control_reg fields
  localparam int SCTL_POL = 0; // tx_polarity_sel: 1 = inverted line
  localparam int SCTL_DIR = 1; // bit_order_sel: 1 = MSB first

  // rx_error_status_reg fields
  localparam int ERR_OVERRUN = 0;
  localparam int ERR_FRAME   = 1;
  localparam int ERR_PARITY  = 2;

  // tx_status_reg fields
  localparam int TXST_SHIFT = 0; // shift register busy
  localparam int TXST_BUF   = 1; // tx_buffer holds an unsent byte

  // Interrupt status and mask fields
  localparam int IRQ_TXDONE = 0; // tx_done_irq
  localparam int IRQ_RXDONE = 1;
  localparam int IRQ_RXERR  = 2;

  // Reset values and limits of the setup registers
  localparam logic [3:0] CKSEL_RESET = 4'h0;
  localparam logic [7:0] BAUD_RESET  = 8'hFF;
  localparam logic [7:0] BAUD_MIN    = 8'h02; // Mid-bit sampling needs two ticks per bit
  localparam logic [3:0] CKSEL_MAX   = 4'hA;  // Prescaler divides by at most 2**10

  typedef enum logic [2:0] {
    UAM_IDLE,
    UAM_START,
    UAM_DATA,
    UAM_PARITY,
    UAM_STOP
  } uam_phase_t;

endpackage : uam_pkg

// *** uam_prescaler.sv ***
// Prescaler: one-cycle tick every 2**sel clocks, sel capped at 10, while the unit is powered
`timescale 1ns/1ps
module uam_prescaler #(
  parameter int CNT_W = 10
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       run_in,
  input  wire logic [3:0] sel_in,
  output logic            tick_out
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } uam_pre_state_t;

  uam_pre_state_t st;
  uam_pre_state_t next_st;
  logic [CNT_W-1:0] mask;
  logic [3:0]       sel_eff;

  // Clamp the selection so the mask never exceeds the counter width
  always_comb begin
    sel_eff  = (sel_in > uam_pkg::CKSEL_MAX) ? uam_pkg::CKSEL_MAX : sel_in;
    mask     = CNT_W'((32'h1 << sel_eff) - 32'h1);
    tick_out = run_in && ((st.cnt & mask) == mask);
    next_st  = st;
    // Counter frozen at zero while power is off, acting as the clock stop
    if (!run_in) begin
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : uam_prescaler

// *** uam_node.sv ***
// Remote serial node: drives frames into the unit and samples frames from its transmit line
`timescale 1ns/1ps
module uam_node #(
  parameter int BIT_CLKS = 8
) (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic [15:0] got; // Sampled bits, first bit in bit 0

  // Line rests high between frames, as if pulled up
  initial line_out = 1'b1;

  // Sends n bits, first at bit 0, each one bit period long
  task automatic send(input logic [15:0] f, input int n);
    @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    line_out <= 1'b1;
  endtask : send

  // Finds the start edge, then samples mid-bit; inv undoes an inverted line
  task automatic grab(input int n, input logic inv);
    got = 16'h0000;
    while ((line_in ^ inv) !== 1'b0) @(posedge clk_in);
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      got[i] = line_in ^ inv;
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask : grab
endmodule : uam_node

// *** uam_uart_chk.sv ***
// Checker: bus handshake, pin ownership, idle line and interrupt gating of the serial unit
`timescale 1ns/1ps
module uam_uart_chk #(
  parameter int PRE_W = 10
) (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [5:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        serial_in_line_in,
  input wire logic        serial_out_line_out,
  input wire logic        tx_pin_serial_out,
  input wire logic        rx_pin_serial_out,
  input wire logic        irq_out
);
  logic [7:0] mode_sh;
  logic [2:0] mask_sh;
  logic       acc_w;
  logic       rd_done;

  // Shadow copies of mode and mask, updated at the completing edge only
  assign acc_w   = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  assign rd_done = avs_read_in && !avs_waitrequest_out;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_sh <= uam_pkg::MODE_RESET;
      mask_sh <= 3'h0;
    end else if (acc_w && avs_address_in == uam_pkg::ADDR_MODE) begin
      mode_sh <= avs_writedata_in[7:0];
    end else if (acc_w && avs_address_in == uam_pkg::ADDR_IRQMASK) begin
      mask_sh <= avs_writedata_in[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  chk_wait_first: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("request not held off in its first cycle");
  chk_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("waitrequest longer than one cycle");
  chk_idle_high: assert property (!mode_sh[7] ##1 !mode_sh[7] |-> serial_out_line_out)
    else $error("transmit line not high while unpowered");
  chk_tx_pin: assert property (tx_pin_serial_out == (mode_sh[7] && mode_sh[6]))
    else $error("transmit pin ownership wrong");
  chk_rx_pin: assert property (rx_pin_serial_out == (mode_sh[7] && mode_sh[5]))
    else $error("receive pin ownership wrong");
  chk_irq_mask: assert property (mask_sh == 3'h0 |-> !irq_out)
    else $error("interrupt raised while fully masked");
  chk_unmapped_zero: assert property (rd_done && avs_address_in > uam_pkg::ADDR_IRQMASK
    |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  chk_upper_zero: assert property (rd_done |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_mode_back: assert property (rd_done && avs_address_in == uam_pkg::ADDR_MODE
    |-> avs_readdata_out[7:0] == mode_sh) else $error("mode readback differs");

  // Main scenarios seen
  cov_tx_pin: cover property ($rose(tx_pin_serial_out));
  cov_irq: cover property ($rose(irq_out));
  cov_unmapped: cover property (rd_done && avs_address_in > uam_pkg::ADDR_IRQMASK);
endmodule : uam_uart_chk

bind uam_uart uam_uart_chk #(.PRE_W(PRE_W)) chk_i (.clk_in(clk_in), .resetn_in(resetn_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .serial_in_line_in(serial_in_line_in), .serial_out_line_out(serial_out_line_out),
  .tx_pin_serial_out(tx_pin_serial_out), .rx_pin_serial_out(rx_pin_serial_out),
  .irq_out(irq_out));

// *** async_serial_uart_mode_tb.sv ***
// Testbench: frame table in both directions, then parity faults, interrupts and register edges
`timescale 1ns/1ps
`define CHK(nm, e, a) begin total_checks++; if ((e) !== (a)) begin \
  $display("[ERR] %s exp %h got %h", nm, e, a); miscompares++; end end
module async_serial_uart_mode_tb;
  typedef struct { logic [4:0] f; logic [1:0] s; logic [7:0] d; } uam_row_t;
  uam_row_t rows [6] = '{'{5'h1C, 2'h0, 8'h55}, '{5'h1C, 2'h2, 8'h55}, '{5'h1C, 2'h3, 8'h55},
                         '{5'h12, 2'h0, 8'h36}, '{5'h04, 2'h0, 8'h87}, '{5'h0C, 2'h1, 8'hFF}};
  logic        clk_in, resetn_in, rd, wr, wt, si, so, txp, rxp, irq;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata;
  int          cyc = 0, miscompares = 0, total_checks = 0;

  uam_uart uut (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wt), .serial_in_line_in(si),
    .serial_out_line_out(so), .tx_pin_serial_out(txp), .rx_pin_serial_out(rxp), .irq_out(irq));
  uam_node #(.BIT_CLKS(8)) node (.clk_in(clk_in), .line_in(so), .line_out(si));

  ////////////////////////////////////////////////////////////////////////////////
  // One bus cycle: drive after a rising edge, hold until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    addr  <= a;
    wdata <= {24'h0, d};
    wr    <= w;
    rd    <= !w;
    @(posedge clk_in);
    // Only waitrequest low or the bench timeout ends this wait
    while (wt !== 1'b0) @(posedge clk_in);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    // Outputs are compared only once the completing edge has settled
    @(negedge clk_in);
  endtask : bus
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg
  task automatic rreg(input logic [5:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(nm, e, q)
  endtask : rreg
  // Stop, then setup in the required order, bit period of 8 clocks, enables last
  task automatic cfg(input logic [4:0] f, input logic [1:0] s);
    wreg(uam_pkg::ADDR_MODE, 8'h00);
    wreg(uam_pkg::ADDR_CKSEL, 8'h00);
    wreg(uam_pkg::ADDR_BAUD, 8'h08);
    wreg(uam_pkg::ADDR_MODE, {3'h0, f});
    wreg(uam_pkg::ADDR_SCTL, {6'h0, s});
    wreg(uam_pkg::ADDR_MODE, {3'h4, f});
    wreg(uam_pkg::ADDR_MODE, {3'h7, f});
  endtask : cfg
  // Expected frame bits, first at bit 0: start, data in chosen order, parity, stops
  function automatic logic [15:0] frm(input logic [4:0] f, input logic [1:0] s,
                                      input logic [7:0] d, output int n);
    logic [15:0] b;
    int          k;
    logic        p;
    b = 16'h0000; k = f[2] ? 8 : 7; p = 1'b0; n = 1;
    for (int i = 0; i < k; i++) begin
      b[n] = s[1] ? d[k-1-i] : d[i];
      p = p ^ b[n];
      n++;
    end
    if (f[4:3] != uam_pkg::PAR_NONE) begin
      b[n] = f[4] & (p ^ !f[3]);
      n++;
    end
    b[n]   = 1'b1;
    b[n+1] = f[1];
    n      = n + (f[1] ? 2 : 1);
    return b;
  endfunction : frm
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    logic [15:0] e;
    int          n;
    resetn_in = 1'b0; rd = 1'b0; wr = 1'b0; addr = 6'h00; wdata = 32'h0;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    rreg(uam_pkg::ADDR_MODE, 8'h01, "mode_reset");
    rreg(uam_pkg::ADDR_BAUD, 8'hFF, "baud_reset");
    wreg(uam_pkg::ADDR_IRQMASK, 8'h07);
    // Each row sends one frame and receives one at the same time
    foreach (rows[i]) begin
      cfg(rows[i].f, rows[i].s);
      `CHK("pins_on", 2'b11, {txp, rxp})
      e = frm(rows[i].f, rows[i].s, rows[i].d, n);
      fork
        node.grab(n, rows[i].s[0]);
        wreg(uam_pkg::ADDR_TXBUF, rows[i].d);
        node.send(e, n);
      join
      // The transmit frame ends a few clocks after the node's last mid-bit sample
      repeat (8) @(negedge clk_in);
      `CHK("tx_frame", e, node.got)
      `CHK("irq_line", 1'b1, irq)
      rreg(uam_pkg::ADDR_IRQST, 8'h03, "irq_status");
      rreg(uam_pkg::ADDR_RXBUF, rows[i].f[2] ? rows[i].d : {1'b0, rows[i].d[6:0]}, "rx");
      rreg(uam_pkg::ADDR_ERRST, 8'h00, "rx_err");
      wreg(uam_pkg::ADDR_IRQST, 8'h07);
    end
    // Flipped parity bit: ignored under zero parity, flagged under even parity
    e = frm(5'h0C, 2'h0, 8'hA5, n);
    node.send(e ^ 16'h0200, n);
    rreg(uam_pkg::ADDR_ERRST, 8'h00, "zero_par");
    cfg(5'h1C, 2'h0);
    e = frm(5'h1C, 2'h0, 8'hA5, n);
    node.send(e ^ 16'h0200, n);
    rreg(uam_pkg::ADDR_ERRST, 8'h04, "par_err");
    `CHK("irq_err", 1'b1, irq)
    // Low stop bit onto an unread buffer: framing and overrun together
    node.send(e ^ 16'h0400, n);
    rreg(uam_pkg::ADDR_ERRST, 8'h03, "frame_ovr");
    wreg(uam_pkg::ADDR_IRQMASK, 8'h00);
    `CHK("irq_masked", 1'b0, irq)
    wreg(uam_pkg::ADDR_IRQMASK, 8'h07);
    wreg(uam_pkg::ADDR_IRQST, 8'h07);
    `CHK("irq_clear", 1'b0, irq)
    rreg(6'h28, 8'h00, "unmapped");
    wreg(uam_pkg::ADDR_TXST, 8'hFF);
    rreg(uam_pkg::ADDR_TXST, 8'h00, "ro_txst");
    // Power and enables off: line idles high, pins return to the port
    wreg(uam_pkg::ADDR_MODE, 8'h1C);
    repeat (2) @(negedge clk_in);
    `CHK("idle_line", 1'b1, so)
    `CHK("pins_free", 2'b00, {txp, rxp})
    // Reset in mid-run returns the setup registers to their reset values
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    rreg(uam_pkg::ADDR_BAUD, 8'hFF, "baud_rst2");
    finish_test();
  end
endmodule : async_serial_uart_mode_tb
